//--- src/rpscd_top.sv
// RS-232 port: serial controller, processor latch, status change detector.
// Assumes every input is synchronous to clk_i (100 MHz) and a bus master
// that keeps read and write strobes one cycle long and never overlapping.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "rpscd_consts.svh"
module rpscd_top (
	input  wire logic                     clk_i,
	input  wire logic                     rst_n_i,
	input  wire rpscd_pkg::rpscd_bus_t    bus_i,
	output logic [7:0]                    rdata_o,
	output logic                          data_oe_o,
	input  wire rpscd_pkg::rpscd_status_t modem_status_i,
	input  wire logic                     transmit_baud_output_i,
	input  wire logic                     modem_transmit_clock_i,
	input  wire logic                     receive_clock_in_i,
	input  wire logic                     serial_data_i,
	output logic                          serial_data_o,
	output logic                          dtr_o,
	output logic                          rts_o,
	output logic                          secondary_request_to_send_o,
	output logic                          transmitter_empty_n_o,
	output logic                          tx_holding_ready_n_o,
	output logic                          rx_char_ready_n_o,
	output logic                          irq_tx_empty_o,
	output logic                          irq_tx_ready_o,
	output logic                          irq_rx_ready_o,
	output logic                          combined_timer_status_interrupt_n_o
);
	import rpscd_pkg::*;

	// ************************************************************
	// Bus decode
	// ************************************************************
	logic ctl_sel;
	logic ctl_wr;
	logic ctl_rd;
	logic det_rd;
	logic lat_wr;
	logic a1;

	assign a1      = bus_i.addr[0];
	assign ctl_sel = (~bus_i.serial_controller_select_a_n | ~bus_i.serial_controller_select_b_n)
		& bus_i.cmd;
	assign ctl_wr  = ctl_sel & bus_i.wr & bus_i.write_not_read;
	assign ctl_rd  = ctl_sel & bus_i.rd & ~bus_i.write_not_read;
	assign det_rd  = ~bus_i.status_detector_select_n & bus_i.rd;
	assign lat_wr  = ~bus_i.control_latch_select_n & bus_i.wr;

	// ************************************************************
	// Control registers
	// ************************************************************
	logic [7:0] mode_reg;
	logic [7:0] cmd_reg;
	logic [7:0] baud_reg;
	logic [7:0] latch_reg;
	logic       err_clr;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_reg <= `RPSCD_MODE_RESET;
			cmd_reg  <= `RPSCD_CMD_RESET;
			baud_reg <= `RPSCD_BAUD_RESET;
		end else if (ctl_wr) begin
			unique case (bus_i.addr)
				`RPSCD_REG_STAT_BAUD: baud_reg <= bus_i.wdata;
				`RPSCD_REG_MODE:      mode_reg <= bus_i.wdata;
				`RPSCD_REG_CMD:       cmd_reg  <= bus_i.wdata;
				default:              ;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			latch_reg <= `RPSCD_LAT_RESET;
		end else if (lat_wr) begin
			latch_reg <= bus_i.wdata;
		end
	end

	assign err_clr = ctl_wr && bus_i.addr == `RPSCD_REG_CMD && bus_i.wdata[`RPSCD_CMD_ERR_CLR];

	// ************************************************************
	// Bit clocks
	// ************************************************************
	// Switching the transmit source may give one stray edge; change it only while idle
	logic       tx_clk_level;
	logic       tx_tick;
	logic       rx_ext_rise;
	logic       rx_ext;
	logic       rx_tick;
	logic [7:0] gen_cnt_reg;
	logic       gen_tick;

	assign tx_clk_level = mode_reg[`RPSCD_MODE_EXT_TX] ? modem_transmit_clock_i
		: transmit_baud_output_i;

	rpscd_edge u_tx_edge (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.level_i (tx_clk_level),
		.rise_o  (tx_tick)
	);

	rpscd_edge u_rx_edge (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.level_i (receive_clock_in_i),
		.rise_o  (rx_ext_rise)
	);

	// Internal generator gives a 16x sample enable; one cycle per divisor step
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gen_cnt_reg <= 8'h00;
		end else if (gen_cnt_reg >= baud_reg) begin
			gen_cnt_reg <= 8'h00;
		end else begin
			gen_cnt_reg <= gen_cnt_reg + 8'h01;
		end
	end

	assign gen_tick = (gen_cnt_reg >= baud_reg);
	assign rx_ext   = mode_reg[`RPSCD_MODE_EXT_RX];
	assign rx_tick  = rx_ext ? rx_ext_rise : gen_tick;

	// ************************************************************
	// Transmitter
	// ************************************************************
	rpscd_tx_state_t tx_state_reg;
	logic [7:0]      tx_hold_reg;
	logic            tx_full_reg;
	logic [7:0]      tx_shift_reg;
	logic [2:0]      tx_bit_reg;
	logic            tx_par_reg;
	logic            tx_stop2_reg;
	logic            txd_reg;
	logic            tx_load;
	logic [2:0]      last_bit;
	logic            tx_empty;

	assign last_bit = 3'(`RPSCD_LEN_BASE + {1'b0, mode_reg[`RPSCD_MODE_LEN_HI:`RPSCD_MODE_LEN_LO]});
	assign tx_load  = tx_tick && tx_full_reg && cmd_reg[`RPSCD_CMD_TX_EN]
		&& (tx_state_reg == TX_IDLE || tx_state_reg == TX_FINISH);

	// A write while the holding register is full is dropped
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_hold_reg <= 8'h00;
			tx_full_reg <= 1'b0;
		end else if (tx_load) begin
			tx_full_reg <= 1'b0;
		end else if (ctl_wr && bus_i.addr == `RPSCD_REG_DATA && !tx_full_reg) begin
			tx_hold_reg <= bus_i.wdata;
			tx_full_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_state_reg <= TX_IDLE;
			tx_shift_reg <= 8'h00;
			tx_bit_reg   <= 3'h0;
			tx_par_reg   <= 1'b0;
			tx_stop2_reg <= 1'b0;
			txd_reg      <= 1'b1;
		end else if (tx_load) begin
			tx_shift_reg <= tx_hold_reg;
			tx_bit_reg   <= 3'h0;
			tx_par_reg   <= ~mode_reg[`RPSCD_MODE_PAR_EVEN];
			tx_stop2_reg <= 1'b0;
			txd_reg      <= 1'b0;
			tx_state_reg <= TX_DATA;
		end else if (tx_tick) begin
			unique case (tx_state_reg)
				TX_IDLE: begin
					txd_reg <= 1'b1;
				end
				TX_DATA: begin
					txd_reg      <= tx_shift_reg[0];
					tx_par_reg   <= tx_par_reg ^ tx_shift_reg[0];
					tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
					tx_bit_reg   <= tx_bit_reg + 3'h1;
					if (tx_bit_reg == last_bit) begin
						tx_state_reg <= mode_reg[`RPSCD_MODE_PAR_EN] ? TX_PARITY : TX_STOP;
					end
				end
				TX_PARITY: begin
					txd_reg      <= tx_par_reg;
					tx_state_reg <= TX_STOP;
				end
				TX_STOP: begin
					txd_reg <= 1'b1;
					if (mode_reg[`RPSCD_MODE_STOP2] && !tx_stop2_reg) begin
						tx_stop2_reg <= 1'b1;
					end else begin
						tx_state_reg <= TX_FINISH;
					end
				end
				TX_FINISH: begin
					txd_reg      <= 1'b1;
					tx_state_reg <= TX_IDLE;
				end
			endcase
		end
	end

	assign tx_empty = !tx_full_reg && tx_state_reg == TX_IDLE;

	// ************************************************************
	// Receiver
	// ************************************************************
	rpscd_rx_state_t rx_state_reg;
	logic [3:0]      rx_cnt_reg;
	logic [2:0]      rx_bit_reg;
	logic [7:0]      rx_shift_reg;
	logic            rx_par_reg;
	logic [7:0]      rx_hold_reg;
	logic            rx_rdy_reg;
	logic            par_err_reg;
	logic            ovr_err_reg;
	logic            frm_err_reg;
	logic            rx_sample;
	logic            rx_done;
	logic            rx_rd;
	logic [7:0]      rx_aligned;

	// External 1X clock samples on every rising edge; internal 16x samples mid-bit
	assign rx_sample = rx_tick && (rx_ext || rx_cnt_reg == `RPSCD_X16_LAST);
	assign rx_done   = rx_sample && rx_state_reg == RX_STOP;
	assign rx_rd     = ctl_rd && bus_i.addr == `RPSCD_REG_DATA;
	assign rx_aligned = rx_shift_reg >> (3'h7 - last_bit);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_state_reg <= RX_IDLE;
			rx_cnt_reg   <= 4'h0;
			rx_bit_reg   <= 3'h0;
			rx_shift_reg <= 8'h00;
			rx_par_reg   <= 1'b0;
		end else if (!cmd_reg[`RPSCD_CMD_RX_EN]) begin
			rx_state_reg <= RX_IDLE;
		end else if (rx_tick) begin
			rx_cnt_reg <= rx_cnt_reg + 4'h1;
			unique case (rx_state_reg)
				RX_IDLE: begin
					rx_cnt_reg <= 4'h0;
					rx_bit_reg <= 3'h0;
					rx_par_reg <= ~mode_reg[`RPSCD_MODE_PAR_EVEN];
					if (!serial_data_i) begin
						rx_state_reg <= rx_ext ? RX_DATA : RX_START;
					end
				end
				RX_START: begin
					if (rx_cnt_reg == `RPSCD_X16_MID) begin
						rx_cnt_reg   <= 4'h0;
						rx_state_reg <= serial_data_i ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_sample) begin
						rx_shift_reg <= {serial_data_i, rx_shift_reg[7:1]};
						rx_par_reg   <= rx_par_reg ^ serial_data_i;
						rx_bit_reg   <= rx_bit_reg + 3'h1;
						if (rx_bit_reg == last_bit) begin
							rx_state_reg <= mode_reg[`RPSCD_MODE_PAR_EN] ? RX_PARITY : RX_STOP;
						end
					end
				end
				RX_PARITY: begin
					if (rx_sample) begin
						rx_par_reg   <= rx_par_reg ^ serial_data_i;
						rx_state_reg <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_sample) begin
						rx_state_reg <= RX_IDLE;
					end
				end
			endcase
		end
	end

	// A new character beats a same-cycle data read, so the ready flag stays set
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_hold_reg <= 8'h00;
			rx_rdy_reg  <= 1'b0;
		end else if (rx_done) begin
			rx_hold_reg <= rx_aligned;
			rx_rdy_reg  <= 1'b1;
		end else if (rx_rd) begin
			rx_rdy_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			par_err_reg <= 1'b0;
			ovr_err_reg <= 1'b0;
			frm_err_reg <= 1'b0;
		end else if (rx_done) begin
			par_err_reg <= par_err_reg | (mode_reg[`RPSCD_MODE_PAR_EN] & rx_par_reg);
			ovr_err_reg <= ovr_err_reg | (rx_rdy_reg & ~rx_rd);
			frm_err_reg <= frm_err_reg | ~serial_data_i;
		end else if (err_clr) begin
			par_err_reg <= 1'b0;
			ovr_err_reg <= 1'b0;
			frm_err_reg <= 1'b0;
		end
	end

	// ************************************************************
	// Status change detector
	// ************************************************************
	rpscd_status_t stored;
	logic          mismatch_n;

	rpscd_detect u_detect (
		.clk_i        (clk_i),
		.rst_n_i      (rst_n_i),
		.live_i       (modem_status_i),
		.capture_i    (det_rd & ~a1),
		.stored_o     (stored),
		.mismatch_n_o (mismatch_n)
	);

	assign combined_timer_status_interrupt_n_o = mismatch_n;

	// ************************************************************
	// Read data
	// ************************************************************
	logic [7:0] status_word;
	logic [7:0] rdata_reg;
	logic       oe_reg;

	always_comb begin
		status_word                   = 8'h00;
		status_word[`RPSCD_ST_TXRDY]   = !tx_full_reg;
		status_word[`RPSCD_ST_RXRDY]   = rx_rdy_reg;
		status_word[`RPSCD_ST_TXEMT]   = tx_empty;
		status_word[`RPSCD_ST_PAR_ERR] = par_err_reg;
		status_word[`RPSCD_ST_OVR_ERR] = ovr_err_reg;
		status_word[`RPSCD_ST_FRM_ERR] = frm_err_reg;
		status_word[`RPSCD_ST_DCD]     = 1'b1;
		status_word[`RPSCD_ST_DSR]     = 1'b1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_reg <= 8'h00;
			oe_reg    <= 1'b0;
		end else begin
			oe_reg <= ctl_rd | det_rd;
			if (det_rd) begin
				rdata_reg <= {2'h0, a1 ? stored : modem_status_i};
			end else if (ctl_rd) begin
				unique case (bus_i.addr)
					`RPSCD_REG_DATA:      rdata_reg <= rx_hold_reg;
					`RPSCD_REG_STAT_BAUD: rdata_reg <= status_word;
					`RPSCD_REG_MODE:      rdata_reg <= mode_reg;
					`RPSCD_REG_CMD:       rdata_reg <= cmd_reg;
					default:              ;
				endcase
			end
		end
	end

	assign rdata_o   = rdata_reg;
	assign data_oe_o = oe_reg;

	// ************************************************************
	// Pins and interrupt gating
	// ************************************************************
	// Clear to send is treated as asserted, so the transmitter never waits on it
	assign serial_data_o               = txd_reg;
	assign dtr_o                       = cmd_reg[`RPSCD_CMD_DTR];
	assign rts_o                       = cmd_reg[`RPSCD_CMD_RTS];
	assign secondary_request_to_send_o = ~latch_reg[`RPSCD_LAT_SECONDARY_REQUEST_TO_SEND];
	assign transmitter_empty_n_o       = ~tx_empty;
	assign tx_holding_ready_n_o        = ~(!tx_full_reg && cmd_reg[`RPSCD_CMD_TX_EN]);
	assign rx_char_ready_n_o           = ~rx_rdy_reg;
	assign irq_tx_empty_o = ~transmitter_empty_n_o & latch_reg[`RPSCD_LAT_EN_TXEMT];
	assign irq_tx_ready_o = ~tx_holding_ready_n_o & latch_reg[`RPSCD_LAT_EN_TXRDY];
	assign irq_rx_ready_o = ~rx_char_ready_n_o & latch_reg[`RPSCD_LAT_EN_RXRDY];
endmodule

//--- shared/rpscd_consts.svh
// Constants of the RS-232 port with status change detector.
// Assumes inclusion by bare name from any design or bench file.
`ifndef RPSCD_CONSTS_SVH
`define RPSCD_CONSTS_SVH

// ************************************************************
// Serial controller register indices (A2,A1)
// ************************************************************
`define RPSCD_REG_DATA      2'h0
`define RPSCD_REG_STAT_BAUD 2'h1
`define RPSCD_REG_MODE      2'h2
`define RPSCD_REG_CMD       2'h3

// ************************************************************
// Mode register fields
// ************************************************************
`define RPSCD_MODE_LEN_LO   0
`define RPSCD_MODE_LEN_HI   1
`define RPSCD_MODE_PAR_EN   2
`define RPSCD_MODE_PAR_EVEN 3
`define RPSCD_MODE_STOP2    4
`define RPSCD_MODE_EXT_TX   5
`define RPSCD_MODE_EXT_RX   6
`define RPSCD_MODE_SYNC     7
`define RPSCD_MODE_RESET    8'h03

// ************************************************************
// Command register fields
// ************************************************************
`define RPSCD_CMD_TX_EN     0
`define RPSCD_CMD_DTR       1
`define RPSCD_CMD_RX_EN     2
`define RPSCD_CMD_RTS       3
`define RPSCD_CMD_ERR_CLR   4
`define RPSCD_CMD_RESET     8'h00

// ************************************************************
// Status register fields
// ************************************************************
`define RPSCD_ST_TXRDY      0
`define RPSCD_ST_RXRDY      1
`define RPSCD_ST_TXEMT      2
`define RPSCD_ST_PAR_ERR    3
`define RPSCD_ST_OVR_ERR    4
`define RPSCD_ST_FRM_ERR    5
`define RPSCD_ST_DCD        6
`define RPSCD_ST_DSR        7

// ************************************************************
// Processor latch fields and misc values
// ************************************************************
`define RPSCD_LAT_SECONDARY_REQUEST_TO_SEND      0
`define RPSCD_LAT_EN_TXEMT  1
`define RPSCD_LAT_EN_TXRDY  2
`define RPSCD_LAT_EN_RXRDY  3
`define RPSCD_LAT_RESET     8'h00
`define RPSCD_BAUD_RESET    8'h1f
`define RPSCD_LEN_BASE      3'h4
`define RPSCD_X16_LAST      4'hf
`define RPSCD_X16_MID       4'h7

`endif

//--- shared/rpscd_pkg.sv
// Types of the RS-232 port with status change detector.
// Assumes the constants header is compiled alongside.
package rpscd_pkg;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic       tick;
		logic       ring;
		logic       cts;
		logic       secondary_carrier_detect;
		logic       dcd;
		logic       dsr;
	} rpscd_status_t;

	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
		logic       write_not_read;
		logic       cmd;
		logic       status_detector_select_n;
		logic       serial_controller_select_a_n;
		logic       serial_controller_select_b_n;
		logic       control_latch_select_n;
	} rpscd_bus_t;

	// ************************************************************
	// State machines
	// ************************************************************
	typedef enum logic [4:0] {
		TX_IDLE   = 5'h01,
		TX_DATA   = 5'h02,
		TX_PARITY = 5'h04,
		TX_STOP   = 5'h08,
		TX_FINISH = 5'h10
	} rpscd_tx_state_t;

	typedef enum logic [4:0] {
		RX_IDLE   = 5'h01,
		RX_START  = 5'h02,
		RX_DATA   = 5'h04,
		RX_PARITY = 5'h08,
		RX_STOP   = 5'h10
	} rpscd_rx_state_t;

endpackage

//--- src/rpscd_edge.sv
// Rising edge finder for a bit clock level.
// Assumes the level is synchronous to clk_i.
`timescale 1ns/1ps
module rpscd_edge (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic level_i,
	output logic      rise_o
);
	logic prev_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= level_i;
		end
	end

	assign rise_o = level_i & ~prev_reg;
endmodule

//--- src/rpscd_detect.sv
// Status change detector: last-state latch and comparator.
// Assumes the six status inputs are synchronous to clk_i.
`timescale 1ns/1ps
module rpscd_detect (
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire rpscd_pkg::rpscd_status_t live_i,
	input  wire logic                  capture_i,
	output rpscd_pkg::rpscd_status_t   stored_o,
	output logic                       mismatch_n_o
);
	import rpscd_pkg::*;

	rpscd_status_t stored_reg;

	// Only a new-status read clocks the latch
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stored_reg <= '0;
		end else if (capture_i) begin
			stored_reg <= live_i;
		end
	end

	assign stored_o     = stored_reg;
	assign mismatch_n_o = (stored_reg == live_i);
endmodule

//--- sim/rpscd_modem.sv
// Modem model: free 1X bit clock, serial sender, frame catcher.
// Assumes 8-bit frames, no parity, one stop bit, LSB first.
`timescale 1ns/1ps
module rpscd_modem (
	input  wire logic       txd_i,
	output logic            bit_clk_o,
	output logic            rxd_o,
	output logic [7:0]      got_o,
	output logic            stop_ok_o,
	output int              frames_o
);
	logic [3:0] n;
	initial begin
		bit_clk_o = 1'b0;
		rxd_o = 1'b1;
		n = 4'h0;
		got_o = 8'h00;
		stop_ok_o = 1'b0;
		frames_o = 0;
	end
	// Runs free, like the timer baud output; toggles on falling clk edges, midway between rising ones, so no sample races it
	// A 160 ns bit matches sixteen internal receive ticks at divisor zero
	always #80 bit_clk_o = ~bit_clk_o;
	// Line changes on the falling edge so the rising sample sits mid-bit
	task automatic send(input logic [7:0] b);
		@(negedge bit_clk_o) rxd_o <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			@(negedge bit_clk_o) rxd_o <= b[i];
		end
		@(negedge bit_clk_o) rxd_o <= 1'b1;
	endtask
	always @(negedge bit_clk_o) begin
		if (n == 4'h0) begin
			if (txd_i === 1'b0) n <= 4'h1;
		end else if (n < 4'h9) begin
			got_o <= {txd_i, got_o[7:1]};
			n <= n + 4'h1;
		end else begin
			stop_ok_o <= txd_i;
			frames_o <= frames_o + 1;
			n <= 4'h0;
		end
	end
endmodule

//--- sim/rpscd_top_properties.sv
// Port-level checker of the RS-232 port with status change detector.
// Assumes it is bound into rpscd_top and sees only its ports.
`timescale 1ns/1ps
module rpscd_top_properties (
	input wire logic                     clk_i,
	input wire logic                     rst_n_i,
	input wire rpscd_pkg::rpscd_bus_t    bus_i,
	input wire logic [7:0]               rdata_o,
	input wire logic                     data_oe_o,
	input wire rpscd_pkg::rpscd_status_t modem_status_i,
	input wire logic                     dtr_o,
	input wire logic                     rts_o,
	input wire logic                     secondary_request_to_send_o,
	input wire logic                     transmitter_empty_n_o,
	input wire logic                     tx_holding_ready_n_o,
	input wire logic                     rx_char_ready_n_o,
	input wire logic                     irq_tx_empty_o,
	input wire logic                     irq_tx_ready_o,
	input wire logic                     irq_rx_ready_o,
	input wire logic                     combined_timer_status_interrupt_n_o
);
	import rpscd_pkg::*;
	wire logic rd_new = bus_i.rd && !bus_i.status_detector_select_n && !bus_i.addr[0];
	wire logic ctl = (!bus_i.serial_controller_select_a_n || !bus_i.serial_controller_select_b_n) && bus_i.cmd;
	wire logic cwr = ctl && bus_i.wr && bus_i.write_not_read;
	wire logic crd = ctl && bus_i.rd && !bus_i.write_not_read;
	wire logic lwr = bus_i.wr && !bus_i.control_latch_select_n;
	wire logic irq_n = combined_timer_status_interrupt_n_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_still;
		modem_status_i == $past(modem_status_i);
	endsequence
	AST_NEW_CAPTURE: assert property (rd_new ##1 s_still |-> irq_n) else $error("capture left mismatch");
	AST_CHANGE_LOW: assert property (irq_n && !rd_new ##1 modem_status_i != $past(modem_status_i) |-> !irq_n)
		else $error("change not flagged");
	AST_MISMATCH_HOLD: assert property (!irq_n && !rd_new ##1 s_still |-> !irq_n) else $error("mismatch lost");
	AST_NEW_DATA: assert property (rd_new |=> data_oe_o && rdata_o == {2'h0, $past(modem_status_i)})
		else $error("live status wrong");
	AST_NO_OE: assert property (!bus_i.rd |=> !data_oe_o) else $error("answer without read");
	AST_CTRL_RD: assert property (crd |=> data_oe_o) else $error("controller read unanswered");
	AST_DTR_RTS: assert property (cwr && bus_i.addr == 2'h3 |=>
		dtr_o == $past(bus_i.wdata[1]) && rts_o == $past(bus_i.wdata[3])) else $error("handshake wrong");
	AST_FIXED_MODEM: assert property (crd && bus_i.addr == 2'h1 |=> rdata_o[7:6] == 2'h3)
		else $error("modem inputs not asserted");
	AST_SECONDARY_REQUEST_TO_SEND: assert property (lwr |=> secondary_request_to_send_o == !$past(bus_i.wdata[0]))
		else $error("secondary rts wrong");
	AST_IRQ_GATE: assert property ((irq_tx_empty_o -> !transmitter_empty_n_o) && (irq_tx_ready_o ->
		!tx_holding_ready_n_o) && (irq_rx_ready_o -> !rx_char_ready_n_o)) else $error("irq ungated");
endmodule
bind rpscd_top rpscd_top_properties i_props (.clk_i, .rst_n_i, .bus_i, .rdata_o, .data_oe_o, .modem_status_i,
	.dtr_o, .rts_o, .secondary_request_to_send_o, .transmitter_empty_n_o, .tx_holding_ready_n_o,
	.rx_char_ready_n_o, .irq_tx_empty_o, .irq_tx_ready_o, .irq_rx_ready_o, .combined_timer_status_interrupt_n_o);

//--- sim/rpscd_top_bench.sv
// Self-checking bench of the RS-232 port with status change detector.
// Assumes the modem model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "rpscd_consts.svh"
module rpscd_top_bench;
	import rpscd_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	rpscd_bus_t bus_i;
	rpscd_status_t modem_status_i;
	logic [7:0] rdata_o;
	logic data_oe_o, bclk, rxd, txd, dtr_o, rts_o, secondary_request_to_send, temp_n, thr_n, rxr_n, irq_e, irq_t, irq_r, comb_n;
	int n_mismatch = 0;
	int total_checks = 0;
	always #5 clk_i = ~clk_i;
	rpscd_top i_dut (.clk_i, .rst_n_i, .bus_i, .rdata_o, .data_oe_o, .modem_status_i,
		.transmit_baud_output_i(bclk), .modem_transmit_clock_i(bclk), .receive_clock_in_i(bclk),
		.serial_data_i(rxd), .serial_data_o(txd), .dtr_o, .rts_o, .secondary_request_to_send_o(secondary_request_to_send),
		.transmitter_empty_n_o(temp_n), .tx_holding_ready_n_o(thr_n), .rx_char_ready_n_o(rxr_n),
		.irq_tx_empty_o(irq_e), .irq_tx_ready_o(irq_t), .irq_rx_ready_o(irq_r),
		.combined_timer_status_interrupt_n_o(comb_n));
	rpscd_modem i_modem (.txd_i(txd), .bit_clk_o(bclk), .rxd_o(rxd), .got_o(), .stop_ok_o(), .frames_o());
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic flag(input string what, input logic e, input logic g);
		chk(what, {7'h0, e}, {7'h0, g});
	endtask
	// Sel: 0 and 1 controller selects, 2 detector, 3 latch, 4 nothing selected
	task automatic acc(input int sel, input logic w, input logic wnr, input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus_i.addr <= a;
		bus_i.wdata <= d;
		bus_i.wr <= w;
		bus_i.rd <= !w;
		bus_i.write_not_read <= wnr;
		bus_i.cmd <= sel < 2;
		bus_i.serial_controller_select_a_n <= sel != 0;
		bus_i.serial_controller_select_b_n <= sel != 1;
		bus_i.status_detector_select_n <= sel != 2;
		bus_i.control_latch_select_n <= sel != 3;
		@(posedge clk_i);
		bus_i <= 18'h0000f;
		#1;
	endtask
	task automatic wr(input int sel, input logic [1:0] a, input logic [7:0] d);
		acc(sel, 1'b1, 1'b1, a, d);
	endtask
	task automatic rd(input int sel, input logic [1:0] a, input logic [7:0] e, input string what);
		acc(sel, 1'b0, 1'b0, a, 8'h00);
		chk(what, e, rdata_o);
		flag("oe", sel < 4, data_oe_o);
	endtask
	task automatic t_reset();
		#1;
		flag("secondary_request_to_send", 1'b1, secondary_request_to_send);
		flag("txd", 1'b1, txd);
		flag("temp", 1'b0, temp_n);
		flag("irq", 1'b1, comb_n);
		$display("test reset done");
	endtask
	task automatic t_ctrl();
		rd(0, `RPSCD_REG_MODE, `RPSCD_MODE_RESET, "mode");
		rd(1, `RPSCD_REG_CMD, `RPSCD_CMD_RESET, "cmd");
		acc(0, 1'b1, 1'b0, `RPSCD_REG_CMD, 8'h0f);
		rd(0, `RPSCD_REG_CMD, 8'h00, "wnr");
		wr(1, `RPSCD_REG_CMD, 8'h0f);
		flag("dtr", 1'b1, dtr_o);
		flag("rts", 1'b1, rts_o);
		flag("thr", 1'b0, thr_n);
		rd(0, `RPSCD_REG_CMD, 8'h0f, "cmd");
		rd(4, `RPSCD_REG_DATA, 8'h0f, "unmapped");
		rd(1, `RPSCD_REG_STAT_BAUD, 8'hc5, "stat");
		wr(3, 2'h0, 8'h0f);
		flag("secondary_request_to_send", 1'b0, secondary_request_to_send);
		flag("irq_e", 1'b1, irq_e);
		flag("irq_t", 1'b1, irq_t);
		flag("irq_r", 1'b0, irq_r);
		wr(3, 2'h0, 8'h08);
		flag("mask", 1'b0, irq_e);
		$display("test control done");
	endtask
	task automatic t_detect();
		rpscd_status_t old;
		for (int i = 0; i < 6; i++) begin
			old = modem_status_i;
			@(posedge clk_i);
			modem_status_i <= old ^ (6'h01 << i);
			repeat (2) @(posedge clk_i);
			#1;
			flag("change", 1'b0, comb_n);
			rd(2, 2'h1, {2'h0, old}, "old");
			flag("held", 1'b0, comb_n);
			rd(2, 2'h0, {2'h0, old ^ (6'h01 << i)}, "new");
			flag("clear", 1'b1, comb_n);
		end
		$display("test detect done");
	endtask
	task automatic t_serial();
		int f;
		f = i_modem.frames_o;
		wr(0, `RPSCD_REG_DATA, 8'ha5);
		flag("busy", 1'b1, temp_n);
		flag("thr_full", 1'b1, thr_n);
		for (int k = 0; k < 4000 && i_modem.frames_o == f; k++) @(posedge clk_i);
		chk("txchar", 8'ha5, i_modem.got_o);
		flag("stop", 1'b1, i_modem.stop_ok_o);
		for (int k = 0; k < 400 && temp_n !== 1'b0; k++) @(posedge clk_i);
		flag("empty", 1'b0, temp_n);
		wr(1, `RPSCD_REG_STAT_BAUD, 8'h00);
		i_modem.send(8'h96);
		for (int k = 0; k < 400 && rxr_n !== 1'b0; k++) @(posedge clk_i);
		rd(0, `RPSCD_REG_DATA, 8'h96, "rxint");
		wr(0, `RPSCD_REG_MODE, 8'h43);
		i_modem.send(8'h3c);
		for (int k = 0; k < 400 && rxr_n !== 1'b0; k++) @(posedge clk_i);
		flag("irq_r", 1'b1, irq_r);
		rd(0, `RPSCD_REG_DATA, 8'h3c, "rxchar");
		flag("rxclr", 1'b1, rxr_n);
		$display("test serial done");
	endtask
	initial begin
		bus_i = 18'h0000f;
		modem_status_i = '0;
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		t_reset();
		t_ctrl();
		t_detect();
		t_serial();
		complete_run();
	end
	initial begin
		#200000;
		n_mismatch++;
		complete_run();
	end
endmodule
